// >>> hdl/ldec_pkg.sv
// Purpose: Shared constants and carriers for the loop converter error and
//          configuration register block.
// Assumes: 24-bit serial frames, 8-bit command then 16-bit data, MSB first.
// Notes:   Timer tick widths are fixed here so the state struct is static.

package ldec_pkg;

   // ****************************************************************
   // Register addresses (command byte of a write frame)
   // ****************************************************************
   localparam logic [7:0] ADDR_COMMIT       = 8'h01;
   localparam logic [7:0] ADDR_NO_OPERATION = 8'h02;
   localparam logic [7:0] ADDR_WR_MODE      = 8'h03;
   localparam logic [7:0] ADDR_OUTPUT_CODE  = 8'h04;
   localparam logic [7:0] ADDR_ERR_CFG      = 8'h05;
   localparam logic [7:0] ADDR_LOW_LEVEL    = 8'h06;
   localparam logic [7:0] ADDR_HIGH_LEVEL   = 8'h07;
   localparam logic [7:0] ADDR_DEV_RESET    = 8'h08;
   localparam logic [7:0] ADDR_FIRST        = ADDR_COMMIT;
   localparam logic [7:0] ADDR_LAST         = ADDR_DEV_RESET;
   localparam int         CMD_READ_BIT      = 7;
   localparam logic [15:0] COMMIT_VALUE     = 16'h00ff;

   // ****************************************************************
   // Reset values and field limits
   // ****************************************************************
   localparam int          PROTECT_BIT    = 0;
   localparam logic        WR_MODE_RESET  = 1'b0;
   localparam logic [15:0] ERR_CFG_RESET  = 16'h0102;
   localparam logic [7:0]  LOW_RESET      = 8'h24;
   localparam logic [7:0]  HIGH_RESET     = 8'he8;
   localparam logic [7:0]  LOW_MAX        = 8'h80;
   localparam logic [7:0]  HIGH_MIN       = 8'h80;
   localparam logic [7:0]  ERR_LOW_BYTE   = 8'h00;
   localparam logic [15:0] CODE_DEF_LOW   = 16'h2400;
   localparam logic [15:0] CODE_DEF_HIGH  = 16'he800;

   // ****************************************************************
   // Framing and timing
   // ****************************************************************
   localparam int         FRAME_BITS  = 24;
   localparam logic [4:0] FRAME_LAST  = 5'(FRAME_BITS - 1);
   localparam logic [1:0] INIT_WAIT   = 2'h3;
   localparam int         TICK_MS     = 50;
   localparam int         CLK_KHZ     = 200000;
   localparam int         TICK_CYCLES = TICK_MS * CLK_KHZ;
   localparam int         PRE_W       = 24;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      LOOP_NORMAL  = 2'h0,
      LOOP_SUBST   = 2'h1,
      LOOP_ATTEMPT = 2'h3
   } ldec_loop_e;

   typedef struct packed {
      logic [4:0] spare;
      logic [2:0] reattempt_time;
      logic       loop_reattempt_disable;
      logic       loop_fault_mask;
      logic       loop_fault_pin_disable;
      logic       idle_code_mask;
      logic [2:0] idle_limit;
      logic       link_idle_report_mask;
   } ldec_err_cfg_s;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] low_byte;
   } ldec_level_s;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [15:0] data;
   } ldec_frame_s;

   typedef struct packed {
      logic [23:0] shreg;
      ldec_frame_s word;
      logic        tgl;
   } ldec_link_s;

   typedef struct packed {
      logic             cs_s1;
      logic             cs_s2;
      logic             tg_s1;
      logic             tg_s2;
      logic             tg_prev;
      logic             new_word;
      logic             flt_s1;
      logic             flt_s2;
      logic             strap_s1;
      logic             strap_s2;
      logic [1:0]       init_cnt;
      logic             ready;
      logic             strap;
      logic             protect;
      logic [15:0]      output_code;
      ldec_err_cfg_s    err_cfg;
      logic [7:0]       low_lvl;
      logic [7:0]       high_lvl;
      logic             pend_v;
      logic [7:0]       pend_addr;
      logic [15:0]      pend_data;
      logic [PRE_W-1:0] idle_pre;
      logic [3:0]       idle_ticks;
      logic             tout;
      logic [PRE_W-1:0] try_pre;
      logic [3:0]       try_ticks;
      ldec_loop_e       loop;
      logic [15:0]      drive_code;
      logic             pin_oe;
   } ldec_core_s;

   localparam ldec_core_s CORE_RESET = '{
      protect:     WR_MODE_RESET,
      output_code: CODE_DEF_LOW,
      err_cfg:     ldec_err_cfg_s'(ERR_CFG_RESET),
      low_lvl:     LOW_RESET,
      high_lvl:    HIGH_RESET,
      loop:        LOOP_NORMAL,
      drive_code:  CODE_DEF_LOW,
      default:     '0
   };

   localparam ldec_link_s LINK_RESET = '0;

endpackage : ldec_pkg

// >>> hdl/ldec_regs.sv
// Purpose: Write-mode, output-code, error-configuration and error-level
//          registers of a loop current converter, with the error policy
//          that picks the code actually driven and the open-drain fault pin.
// Assumes: Frames arrive on link_sclk; chip_select_n stays high for at
//          least four mclk periods between frames.
// Notes:   Register read-back and status bits live in a neighbouring block.
//
// Notes on behaviour
// RQ1: Protection off: a write takes effect once chip select returns high.
// RQ2: Protection on: writes wait pending until a commit command arrives.
// RQ3: Output code is an unsigned 16-bit value, bit 15 most significant.
// RQ4: At reset the output code defaults by the sampled strap level.
// RQ5: Retry interval is (field 10:8 plus one) times 50 ms, default 100 ms.
// RQ6: Retry interval unused when loop mask or retry disable is set.
// RQ7: Retry disable clear: reattempt the requested code once per interval.
// RQ8: Retry disable set: reattempt only after the status register is read.
// RQ9: Loop mask clear: a loop fault substitutes the low error code.
// RQ10: Loop mask set: keep driving the requested code through a fault.
// RQ11: Loop fault pulls the fault pin low unless bit 5 is set.
// RQ12: Idle timeout forces the error code unless bit 4 is set; the code also skips it when bit 0 is set.
// RQ13: Every write restarts the idle timer; expiry flags a timeout.
// RQ14: A no-operation write restarts the timer and changes nothing.
// RQ15: Idle timeout is (field 3:1 plus one) times 50 ms, default 100 ms.
// RQ16: Bit 0 clear: timeout pulls fault pin low; set: no timeout report.
// RQ17: Error configuration resets to 0x0102.
// RQ18: Low error code is the low level byte above a zero byte.
// RQ19: Low level accepts only values up to 0x80, else keeps old value.
// RQ20: Low level resets to 0x24.
// RQ21: High level is upper byte of error code; only 0x80 and up accepted.
// RQ22: Commit is 0x00ff written to address 0x01; loads the pending write.
// RQ23: Timeout error code uses high level if strap high, else low level.

module ldec_regs #(
   parameter int TICK_CYCLES = ldec_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Serial link
   input  wire logic        link_sclk,
   input  wire logic        chip_select_n,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // Loop supervision
   input  wire logic        loop_fault,
   input  wire logic        status_read,
   // Strap
   input  wire logic        error_level_strap_pin,
   // Open-drain fault pin
   output logic             fault_pin_n_o,
   output logic             fault_pin_n_oe,
   // Converter side
   output logic [15:0]      drive_code,
   output logic             error_level_strap,
   output logic             spi_idle_error,
   output logic             loop_substitute
);

   localparam int PW = ldec_pkg::PRE_W;
   localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << PW)) begin : g_bad_tick
      $error("TICK_CYCLES must fit the tick prescaler");
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [3:0] tick_limit(input logic [2:0] field);
      tick_limit = {1'b0, field} + 4'h1;
   endfunction : tick_limit

   function automatic ldec_pkg::ldec_core_s apply_write(
      input ldec_pkg::ldec_core_s st,
      input logic [7:0]           addr,
      input logic [15:0]          data);
      ldec_pkg::ldec_core_s r;
      ldec_pkg::ldec_level_s lv;
      r  = st;
      lv = ldec_pkg::ldec_level_s'(data);
      case (addr)
         ldec_pkg::ADDR_WR_MODE: begin
            r.protect = data[ldec_pkg::PROTECT_BIT];
         end
         ldec_pkg::ADDR_OUTPUT_CODE: begin
            r.output_code = data; // RQ3
         end
         ldec_pkg::ADDR_ERR_CFG: begin
            r.err_cfg       = ldec_pkg::ldec_err_cfg_s'(data);
            r.err_cfg.spare = '0;
         end
         ldec_pkg::ADDR_LOW_LEVEL: begin
            if (lv.level <= ldec_pkg::LOW_MAX) begin // RQ19
               r.low_lvl = lv.level;
            end
         end
         ldec_pkg::ADDR_HIGH_LEVEL: begin
            if (lv.level >= ldec_pkg::HIGH_MIN) begin // RQ21
               r.high_lvl = lv.level;
            end
         end
         // Commit, no-operation and device reset alter nothing here
         default: begin
         end
      endcase
      return r;
   endfunction : apply_write

   // ****************************************************************
   // Link domain: shift in frames
   // ****************************************************************
   ldec_pkg::ldec_link_s l;
   ldec_pkg::ldec_link_s next_l;
   logic [4:0]           bit_cnt;

   always_comb begin
      next_l       = l;
      next_l.shreg = {l.shreg[22:0], sdi};
      if (bit_cnt == ldec_pkg::FRAME_LAST) begin
         // Several words per frame keep only the last one
         next_l.word = ldec_pkg::ldec_frame_s'({l.shreg[22:0], sdi});
         next_l.tgl  = ~l.tgl;
      end
   end

   always_ff @(posedge link_sclk or negedge rstn) begin
      if (!rstn) begin
         l <= ldec_pkg::LINK_RESET;
      end else begin
         l <= next_l;
      end
   end

   // Chip select clears the bit count, so each frame starts aligned
   always_ff @(posedge link_sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt <= '0;
      end else if (bit_cnt == ldec_pkg::FRAME_LAST) begin
         bit_cnt <= '0;
      end else begin
         bit_cnt <= bit_cnt + 5'h1;
      end
   end

   assign sdo    = l.shreg[23];
   assign sdo_oe = ~chip_select_n;

   // ****************************************************************
   // Core domain: registers and error policy
   // ****************************************************************
   ldec_pkg::ldec_core_s    s;
   ldec_pkg::ldec_core_s    next_s;
   ldec_pkg::ldec_err_cfg_s cfg;
   logic                    take;
   logic                    valid_wr;
   logic                    commit_hit;
   logic                    idle_wrap;
   logic                    idle_hit;
   logic                    try_wrap;
   logic                    retry_on;
   logic                    idle_report;

   always_comb begin
      next_s      = s;
      cfg         = s.err_cfg;
      take        = 1'b0;
      valid_wr    = 1'b0;
      commit_hit  = 1'b0;
      idle_wrap   = (s.idle_pre == TICK_LAST);
      try_wrap    = (s.try_pre == TICK_LAST);
      idle_hit    = 1'b0;
      retry_on    = 1'b0;
      idle_report = 1'b0;

      // Synchronisers
      next_s.cs_s1    = chip_select_n;
      next_s.cs_s2    = s.cs_s1;
      next_s.tg_s1    = l.tgl;
      next_s.tg_s2    = s.tg_s1;
      next_s.tg_prev  = s.tg_s2;
      next_s.flt_s1   = loop_fault;
      next_s.flt_s2   = s.flt_s1;
      next_s.strap_s1 = error_level_strap_pin;
      next_s.strap_s2 = s.strap_s1;

      // Strap capture once the synchroniser has filled
      if (!s.ready) begin
         next_s.init_cnt = s.init_cnt + 2'h1;
         if (s.init_cnt == ldec_pkg::INIT_WAIT) begin
            next_s.ready       = 1'b1;
            next_s.strap       = s.strap_s2;
            next_s.output_code = s.strap_s2 ? ldec_pkg::CODE_DEF_HIGH
                                            : ldec_pkg::CODE_DEF_LOW; // RQ4
         end
      end

      // ****************************************************************
      // Write intake
      // ****************************************************************
      // Word is read only while chip select is high and the strap has been captured
      take = s.new_word & s.cs_s2 & s.ready; // RQ1
      if (take) begin
         next_s.new_word = 1'b0;
      end
      if (s.tg_s2 != s.tg_prev) begin
         next_s.new_word = 1'b1;
      end
      valid_wr = take && !l.word.cmd[ldec_pkg::CMD_READ_BIT]
                 && l.word.cmd >= ldec_pkg::ADDR_FIRST
                 && l.word.cmd <= ldec_pkg::ADDR_LAST;
      commit_hit = (l.word.cmd == ldec_pkg::ADDR_COMMIT)
                   && (l.word.data == ldec_pkg::COMMIT_VALUE);
      if (valid_wr) begin
         if (s.protect) begin
            if (commit_hit) begin
               if (s.pend_v) begin
                  next_s = apply_write(next_s, s.pend_addr,
                                       s.pend_data); // RQ22
               end
               next_s.pend_v = 1'b0;
            end else if (l.word.cmd != ldec_pkg::ADDR_COMMIT &&
                         l.word.cmd != ldec_pkg::ADDR_NO_OPERATION) begin
               next_s.pend_v    = 1'b1; // RQ2
               next_s.pend_addr = l.word.cmd;
               next_s.pend_data = l.word.data;
            end
         end else begin
            next_s = apply_write(next_s, l.word.cmd, l.word.data); // RQ1
         end
      end

      // ****************************************************************
      // Idle timer
      // ****************************************************************
      idle_hit = !s.tout && idle_wrap
                 && (s.idle_ticks + 4'h1
                     == tick_limit(cfg.idle_limit)); // RQ15
      if (valid_wr) begin
         // Any valid write, no-operation included, restarts the count
         next_s.idle_pre   = '0; // RQ13 RQ14
         next_s.idle_ticks = '0;
         next_s.tout       = 1'b0;
      end else if (!s.tout) begin
         if (idle_wrap) begin
            next_s.idle_pre   = '0;
            next_s.idle_ticks = s.idle_ticks + 4'h1;
         end else begin
            next_s.idle_pre = s.idle_pre + PW'(1);
         end
      end
      if (idle_hit) begin
         next_s.tout = 1'b1; // RQ13
      end

      // ****************************************************************
      // Loop fault handling
      // ****************************************************************
      retry_on = !cfg.loop_reattempt_disable
                 && !cfg.loop_fault_mask; // RQ6
      next_s.try_pre   = '0;
      next_s.try_ticks = '0;
      case (s.loop)
         ldec_pkg::LOOP_NORMAL: begin
            if (s.flt_s2 && !cfg.loop_fault_mask) begin
               next_s.loop = ldec_pkg::LOOP_SUBST; // RQ9
            end
         end
         ldec_pkg::LOOP_SUBST: begin
            if (cfg.loop_fault_mask) begin
               next_s.loop = ldec_pkg::LOOP_NORMAL; // RQ10
            end else if (retry_on) begin
               if (try_wrap) begin
                  next_s.try_ticks = s.try_ticks + 4'h1;
                  if (s.try_ticks + 4'h1
                      == tick_limit(cfg.reattempt_time)) begin // RQ5
                     next_s.loop      = ldec_pkg::LOOP_ATTEMPT; // RQ7
                     next_s.try_ticks = '0;
                  end
               end else begin
                  next_s.try_pre   = s.try_pre + PW'(1);
                  next_s.try_ticks = s.try_ticks;
               end
            end else if (status_read) begin
               next_s.loop = ldec_pkg::LOOP_ATTEMPT; // RQ8
            end
         end
         ldec_pkg::LOOP_ATTEMPT: begin
            // One tick of the requested code lets the loop settle
            if (try_wrap) begin
               next_s.loop = ldec_pkg::LOOP_NORMAL;
            end else begin
               next_s.try_pre = s.try_pre + PW'(1);
            end
         end
         default: begin
            next_s.loop = ldec_pkg::LOOP_NORMAL;
         end
      endcase

      // ****************************************************************
      // Drive code and fault pin
      // ****************************************************************
      idle_report   = s.tout && !cfg.link_idle_report_mask; // RQ16
      next_s.pin_oe = (s.flt_s2 && !cfg.loop_fault_pin_disable) // RQ11
                      || idle_report; // RQ16
      if (idle_report && !cfg.idle_code_mask) begin // RQ12
         next_s.drive_code = s.strap
                             ? {s.high_lvl, ldec_pkg::ERR_LOW_BYTE}
                             : {s.low_lvl, ldec_pkg::ERR_LOW_BYTE}; // RQ23
      end else if (s.loop == ldec_pkg::LOOP_SUBST) begin
         next_s.drive_code = {s.low_lvl, ldec_pkg::ERR_LOW_BYTE}; // RQ18
      end else begin
         next_s.drive_code = s.output_code; // RQ3
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s <= ldec_pkg::CORE_RESET; // RQ17 RQ20
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign fault_pin_n_o     = 1'b0;
   assign fault_pin_n_oe    = s.pin_oe;
   assign drive_code        = s.drive_code;
   assign error_level_strap = s.strap;
   assign spi_idle_error    = s.tout;
   assign loop_substitute   = (s.loop == ldec_pkg::LOOP_SUBST);

endmodule : ldec_regs

// >>> sim/ldec_checker.sv
// Purpose: Port-level timing checks for ldec_regs
// Assumes: TICK_CYCLES matches the bound instance
// Notes:   Frame-driven causes are allowed a short cycle window
module ldec_checker #(
   parameter int TICK_CYCLES = 400
) (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rstn,
   // Link and converter side
   input wire logic        chip_select_n,
   input wire logic        fault_pin_n_o,
   input wire logic        fault_pin_n_oe,
   input wire logic [15:0] drive_code,
   input wire logic        error_level_strap,
   input wire logic        spi_idle_error,
   input wire logic        loop_substitute
);
   timeunit 1ns;
   timeprecision 100ps;
   int quiet;
   int since_rst;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // Quiet counts from the last frame, so it undercounts the timer only when that frame was not a valid write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         quiet     <= 0;
         since_rst <= 0;
      end else begin
         quiet     <= chip_select_n ? quiet + 1 : 0;
         since_rst <= (since_rst < 20) ? since_rst + 1 : since_rst;
      end
   end

   AST_OPEN_DRAIN: assert property (fault_pin_n_o == 1'b0)
      else $error("fault pin output not low");
   AST_RESET_CODE: assert property ($rose(rstn) |->
      drive_code == 16'h2400 && !spi_idle_error && !fault_pin_n_oe)
      else $error("wrong values just after reset");
   AST_DEFAULT_HOLD: assert property (since_rst < 4 |->
      drive_code == 16'h2400 && !error_level_strap)
      else $error("code left default too early");
   AST_STRAP_HELD: assert property (since_rst == 20 |->
      $stable(error_level_strap))
      else $error("strap level changed after start");
   AST_SUBST_BYTE: assert property (loop_substitute &&
      $past(loop_substitute) && !spi_idle_error &&
      !$past(spi_idle_error) |-> drive_code[7:0] == 8'h00)
      else $error("substitute code low byte not zero");
   AST_IDLE_NOT_EARLY: assert property ($rose(spi_idle_error) |->
      quiet >= TICK_CYCLES)
      else $error("idle error before one tick");
   AST_IDLE_LATE: assert property (quiet == 8 * TICK_CYCLES + 16 |->
      spi_idle_error)
      else $error("idle error missing after longest limit");
   AST_DRIVE_CAUSE: assert property ($changed(drive_code) |->
      loop_substitute || $past(loop_substitute) ||
      $past(loop_substitute, 2) || spi_idle_error ||
      $past(spi_idle_error) || $past(spi_idle_error, 2) ||
      quiet < 16 || since_rst < 8)
      else $error("code changed without a cause");
endmodule : ldec_checker

bind ldec_regs ldec_checker #(.TICK_CYCLES(TICK_CYCLES)) ldec_checker_inst (
   .mclk, .rstn, .chip_select_n, .fault_pin_n_o, .fault_pin_n_oe,
   .drive_code, .error_level_strap, .spi_idle_error, .loop_substitute);

// >>> sim/ldec_host.sv
// Purpose: Host serial master sending write frames to ldec_regs
// Assumes: Tasks are called from the bench; link clock idles low
// Notes:   Released data line shows the inverse of its last bit
module ldec_host (
   // Serial link
   output logic link_sclk,
   output logic chip_select_n,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      link_sclk     = 1'b0;
      chip_select_n = 1'b1;
      sdi           = 1'b0;
   end

   task automatic send(input logic [7:0] cmd, input logic [15:0] data);
      logic [23:0] word;
      word = {cmd, data};
      chip_select_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = word[i];
         #16 link_sclk = 1'b1;
         #16 link_sclk = 1'b0;
      end
      #16 chip_select_n = 1'b1;
      sdi = ~sdi;
      // Gap well above the four-cycle minimum
      #40;
   endtask : send

   task automatic commit();
      send(ldec_pkg::ADDR_COMMIT, ldec_pkg::COMMIT_VALUE);
   endtask : commit

   task automatic keep_alive();
      send(ldec_pkg::ADDR_NO_OPERATION, 16'h0000);
   endtask : keep_alive
endmodule : ldec_host

// >>> sim/ldec_regs_tb.sv
// Purpose: Self-checking bench for ldec_regs
// Assumes: Short tick of 400 cycles keeps the run brief
// Notes:   Outputs are sampled on the falling edge
module ldec_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK  = 400;
   localparam int LIMIT = 30000;
   typedef struct packed {
      logic [7:0]  cmd;
      logic [15:0] data;
      logic [15:0] exp;
   } ldec_row_s;

   logic        mclk;
   logic        rstn;
   logic        loop_fault;
   logic        status_read;
   logic        error_level_strap_pin;
   wire logic   link_sclk;
   wire logic   chip_select_n;
   wire logic   sdi;
   logic        sdo;
   logic        sdo_oe;
   logic        fault_pin_n_o;
   logic        fault_pin_n_oe;
   logic [15:0] drive_code;
   logic        error_level_strap;
   logic        spi_idle_error;
   logic        loop_substitute;
   int          num_errors;
   int          checks;
   int          cyc;
   ldec_row_s   rows [6] = '{
      '{8'h04, 16'h1234, 16'h1234},
      '{8'h84, 16'hffff, 16'h1234},
      '{8'h09, 16'haaaa, 16'h1234},
      '{8'h04, 16'hffff, 16'hffff},
      '{8'h02, 16'h5a5a, 16'hffff},
      '{8'h04, 16'h0000, 16'h0000}
   };

   ldec_regs #(.TICK_CYCLES(TICK)) ldec_regs_inst (
      .mclk, .rstn, .link_sclk, .chip_select_n, .sdi, .sdo, .sdo_oe,
      .loop_fault, .status_read, .error_level_strap_pin, .fault_pin_n_o,
      .fault_pin_n_oe, .drive_code, .error_level_strap, .spi_idle_error,
      .loop_substitute);
   ldec_host ldec_host_inst (.link_sclk, .chip_select_n, .sdi);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      // Ends on a falling edge so callers read settled outputs
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      ldec_host_inst.send(cmd, data);
      tick(12);
   endtask : wr

   task automatic do_reset(input logic level);
      @(posedge mclk);
      rstn                  <= 1'b0;
      error_level_strap_pin <= level;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      tick(10);
   endtask : do_reset

   // Bounded wait; the check after it catches a miss
   task automatic wait_subst(input logic val, input int lim);
      int n;
      n = 0;
      while (loop_substitute !== val && n < lim) begin
         tick(1);
         n++;
      end
      tick(2);
   endtask : wait_subst

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      rstn                  = 1'b0;
      loop_fault            = 1'b0;
      status_read           = 1'b0;
      error_level_strap_pin = 1'b0;
      num_errors            = 0;
      checks                = 0;
      cyc                   = 0;
      do_reset(1'b1);
      chk(drive_code, 16'he800);
      chk(error_level_strap, 1'b1);
      wr(8'h04, 16'h1111);
      tick(770);
      chk(spi_idle_error, 1'b0);
      tick(40);
      chk(spi_idle_error, 1'b1);
      chk(fault_pin_n_oe, 1'b1);
      chk(drive_code, 16'he800);
      ldec_host_inst.keep_alive();
      tick(12);
      chk(spi_idle_error, 1'b0);
      chk(drive_code, 16'h1111);
      wr(8'h07, 16'h9100);
      wr(8'h07, 16'h7000);
      tick(830);
      chk(drive_code, 16'h9100);
      do_reset(1'b0);
      chk(drive_code, 16'h2400);
      foreach (rows[i]) begin
         wr(rows[i].cmd, rows[i].data);
         chk(drive_code, rows[i].exp);
         chk(sdo, rows[i].cmd[7]);
         chk(sdo_oe, 1'b0);
      end
      wr(8'h03, 16'h0001);
      wr(8'h04, 16'h4321);
      chk(drive_code, 16'h0000);
      ldec_host_inst.commit();
      tick(12);
      chk(drive_code, 16'h4321);
      wr(8'h03, 16'h0000);
      ldec_host_inst.commit();
      wr(8'h06, 16'h9000);
      wr(8'h05, 16'h010e);
      @(posedge mclk);
      loop_fault <= 1'b1;
      tick(10);
      chk(loop_substitute, 1'b1);
      chk(drive_code, 16'h2400);
      chk(fault_pin_n_oe, 1'b1);
      wr(8'h06, 16'h8000);
      chk(drive_code, 16'h8000);
      wait_subst(1'b0, 1000);
      chk(drive_code, 16'h4321);
      wr(8'h05, 16'h018e);
      wait_subst(1'b1, 600);
      tick(1000);
      chk(loop_substitute, 1'b1);
      @(posedge mclk);
      status_read <= 1'b1;
      @(posedge mclk);
      status_read <= 1'b0;
      tick(4);
      chk(drive_code, 16'h4321);
      wr(8'h05, 16'h014e);
      tick(500);
      chk(loop_substitute, 1'b0);
      chk(drive_code, 16'h4321);
      wr(8'h05, 16'h012e);
      tick(5);
      chk(fault_pin_n_oe, 1'b0);
      chk(loop_substitute, 1'b1);
      @(posedge mclk);
      loop_fault <= 1'b0;
      wr(8'h05, 16'h0152);
      tick(830);
      chk(spi_idle_error, 1'b1);
      chk(fault_pin_n_oe, 1'b1);
      chk(drive_code, 16'h4321);
      wr(8'h05, 16'h0103);
      tick(830);
      chk(fault_pin_n_oe, 1'b0);
      chk(drive_code, 16'h4321);
      wr(8'h05, 16'h0102);
      tick(830);
      chk(drive_code, 16'h8000);
      end_of_test();
   end
endmodule : ldec_regs_tb
